// [rtl/fsps_defines.vh]
// fsps_defines.vh: constants for the flash self-programming sequencer
// assumes inclusion by bare name from rtl/ design files
`ifndef FSPS_DEFINES_VH
`define FSPS_DEFINES_VH
// control/status register bit positions
`define FSPS_BIT_EN       0
`define FSPS_BIT_ERASE    1
`define FSPS_BIT_WRITE    2
`define FSPS_BIT_LOCK     3
`define FSPS_BIT_CLR      4
`define FSPS_BIT_BUSY     6
`define FSPS_BIT_IE       7
// command patterns on bits 5..0 (bit 7 is don't care, bit 6 reads only)
`define FSPS_CMD_MASK     6'h3f
`define FSPS_CMD_LOAD     6'h01
`define FSPS_CMD_ERASE    6'h03
`define FSPS_CMD_WRITE    6'h05
`define FSPS_CMD_LOCK     6'h09
`define FSPS_CMD_CLR      6'h11
// timed window between register write and store instruction, cycles
`define FSPS_WINDOW       3'h4
// page geometry: 64 words per page
`define FSPS_WORD_W       6
`define FSPS_WORD_LSB     1
`define FSPS_WORD_MSB     6
`define FSPS_PAGE_LSB     7
`define FSPS_PAGE_MSB     15
`define FSPS_PAGE_W       9
`define FSPS_WORDS        64
// addresses
`define FSPS_APP_RESET    16'h0000
`define FSPS_BOOT_RESET   16'h7000
`define FSPS_HALT_PAGE    9'h0e0
// lock field, six programmable bits
`define FSPS_LOCK_W       6
`define FSPS_LOCK_ERASED  6'h3f
// programming time per operation, microseconds, and cycle count at 10 MHz
`define FSPS_PROG_US      3700
`define FSPS_CLK_MHZ      10
`define FSPS_PROG_CYC     (`FSPS_PROG_US * `FSPS_CLK_MHZ)
`define FSPS_CNT_W        16
`endif

// [rtl/fsps_page_buffer.v]
// fsps_page_buffer.v: temporary page buffer with per-word written flags
// assumes writes and clears come from the sequencer on the same clock
`timescale 1ns/100ps
`include "fsps_defines.vh"
module fsps_page_buffer (
  // clock and reset
  input  wire                    ref_clk_i,
  input  wire                    reset_i,
  // write side
  input  wire                    wr_i,
  input  wire [`FSPS_WORD_W-1:0] wr_addr_i,
  input  wire [15:0]             wr_data_i,
  input  wire                    clear_i,
  // read side
  input  wire [`FSPS_WORD_W-1:0] rd_addr_i,
  output wire [15:0]             rd_data_o,
  output wire                    rd_valid_o
);
  reg [15:0]              mem [0:`FSPS_WORDS-1];
  reg [`FSPS_WORDS-1:0]   valid_q;
  genvar gi;
  // per-entry valid flag; clear drops the whole buffer at once, data is kept stale
  generate
    for (gi = 0; gi < `FSPS_WORDS; gi = gi + 1) begin : g_ent
      always @(posedge ref_clk_i) begin
        if (reset_i || clear_i) begin
          valid_q[gi] <= 1'b0;
        end else if (wr_i && wr_addr_i == gi) begin
          valid_q[gi] <= 1'b1;
        end
      end
    end
  endgenerate
  // data array, no reset needed since valid flags gate it
  always @(posedge ref_clk_i) begin
    if (wr_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end
  // unwritten words read as erased flash
  assign rd_data_o  = valid_q[rd_addr_i] ? mem[rd_addr_i] : 16'hffff;
  assign rd_valid_o = valid_q[rd_addr_i];
endmodule // fsps_page_buffer

// [rtl/fsps_sequencer.v]
// fsps_sequencer.v: flash self-programming sequencer top
// assumes cpu strobes are single cycle on ref_clk_i; fuse and eeprom busy are pins
// Behaviour
// - reset vector is 0x0000 with boot fuse high, boot address when low
// - fuse value is input only; cpu has no path to change it
// - 16-bit pointer: low bits word within page, high bits page
// - pointer is latched when an operation starts
// - lock setting ignores the pointer entirely
// - load instructions address flash by byte, bit 0 selects byte
// - erase pattern X0000011 plus store within four cycles, page field only
// - halting-section erase or write stops the cpu
// - pattern 00000001 plus store loads data pair at word field
// - page buffer clears after write, on busy-clear request, on reset
// - eeprom write during loading discards buffer contents
// - write pattern X0000101 plus store, page field used, data ignored
// - interrupt held while enabled and enable bit is clear
// - concurrent section reads blocked and busy flag set while busy
// - busy flag stays set until busy-clear request is written
// - lock pattern X0001001 plus store, values in low data register
// - each zero in data bits 5..0 programs the lock bit
// - lock programming leaves whole flash readable
// - buffer loads accepted in any order, before or after erase
// - enable and lock-set bits auto-clear when no store follows
// - lock bits only cleared by chip erase; code also restores them on reset_i
`timescale 1ns/100ps
`include "fsps_defines.vh"
module fsps_sequencer #(
  parameter PROG_CYCLES = `FSPS_PROG_CYC
) (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        reset_i,
  // fuse and chip erase pins
  input  wire        boot_vector_fuse_i,
  input  wire        chip_erase_i,
  // cpu control register write and store instruction
  input  wire        ctrl_wr_i,
  input  wire [7:0]  ctrl_wdata_i,
  input  wire        store_i,
  input  wire        load_i,
  input  wire [15:0] pointer_i,
  input  wire [15:0] data_pair_i,
  // eeprom activity
  input  wire        eeprom_wr_i,
  // cpu side status
  output reg  [7:0]  ctrl_status_o,
  output reg         irq_o,
  output reg         cpu_halt_o,
  output reg         read_block_o,
  output reg  [15:0] reset_vector_o,
  output reg  [15:0] load_byte_addr_o,
  output reg         load_byte_sel_o,
  output reg  [7:0]  load_data_o,
  // flash array side
  output reg         flash_erase_o,
  output reg         flash_write_o,
  output reg  [`FSPS_PAGE_W-1:0] flash_page_o,
  output reg  [`FSPS_LOCK_W-1:0] lock_bits_o
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_ARMED = 2'd1;
  localparam ST_PROG  = 2'd2;
  localparam OP_ERASE = 2'd0;
  localparam OP_WRITE = 2'd1;
  localparam OP_LOCK  = 2'd2;

  // pin synchronisers for external levels
  reg [1:0] fuse_sync_q;
  reg [1:0] cerase_sync_q;
  reg [1:0] eewr_sync_q;
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      fuse_sync_q   <= 2'b11;
      cerase_sync_q <= 2'b00;
      eewr_sync_q   <= 2'b00;
    end else begin
      fuse_sync_q   <= {fuse_sync_q[0], boot_vector_fuse_i};
      cerase_sync_q <= {cerase_sync_q[0], chip_erase_i};
      eewr_sync_q   <= {eewr_sync_q[0], eeprom_wr_i};
    end
  end
  wire fuse_s   = fuse_sync_q[1];
  wire cerase_s = cerase_sync_q[1];
  wire eewr_s   = eewr_sync_q[1];

  // control state
  reg [1:0]              state_q, state_d;
  reg [5:0]              cmd_q, cmd_d;
  reg                    ie_q, ie_d;
  reg                    busy_q, busy_d;
  reg [2:0]              win_q, win_d;
  reg [`FSPS_CNT_W-1:0]  cnt_q, cnt_d;
  reg [1:0]              op_q, op_d;
  reg [`FSPS_PAGE_W-1:0] page_q, page_d;
  reg                    halt_d;
  reg [`FSPS_LOCK_W-1:0] lock_q, lock_d;
  reg                    loading_q, loading_d;
  reg                    buf_wr;
  reg                    buf_clr;

  wire [`FSPS_WORD_W-1:0] word_f = pointer_i[`FSPS_WORD_MSB:`FSPS_WORD_LSB];
  wire [`FSPS_PAGE_W-1:0] page_f = pointer_i[`FSPS_PAGE_MSB:`FSPS_PAGE_LSB];
  wire en_bit = (state_q != ST_IDLE);

  // page buffer holds the loaded words until a page write, busy clear, eeprom write or reset empties it
  wire [15:0] buf_rd_data;
  fsps_page_buffer u_buf (
    .ref_clk_i  (ref_clk_i),
    .reset_i    (reset_i),
    .wr_i       (buf_wr),
    .wr_addr_i  (word_f),
    .wr_data_i  (data_pair_i),
    .clear_i    (buf_clr),
    .rd_addr_i  (word_f),
    .rd_data_o  (buf_rd_data),
    .rd_valid_o ()
  );

  // sequencer: arm on register write, fire on store within the window
  always @* begin
    state_d   = state_q;
    cmd_d     = cmd_q;
    ie_d      = ie_q;
    busy_d    = busy_q;
    win_d     = win_q;
    cnt_d     = cnt_q;
    op_d      = op_q;
    page_d    = page_q;
    lock_d    = lock_q;
    loading_d = loading_q;
    buf_wr    = 1'b0;
    buf_clr   = 1'b0;
    halt_d    = 1'b0;
    if (ctrl_wr_i) begin
      ie_d = ctrl_wdata_i[`FSPS_BIT_IE];
    end
    case (state_q)
      ST_IDLE: begin
        if (ctrl_wr_i && ctrl_wdata_i[`FSPS_BIT_EN]) begin
          state_d = ST_ARMED;
          cmd_d   = ctrl_wdata_i[5:0] & `FSPS_CMD_MASK;
          win_d   = `FSPS_WINDOW;
        end
      end
      ST_ARMED: begin
        if (store_i) begin
          state_d = ST_IDLE;
          case (cmd_q)
            `FSPS_CMD_LOAD: begin
              buf_wr    = 1'b1;
              loading_d = 1'b1;
            end
            `FSPS_CMD_ERASE: begin
              state_d = ST_PROG;
              op_d    = OP_ERASE;
              page_d  = page_f;
              cnt_d   = PROG_CYCLES[`FSPS_CNT_W-1:0];
              busy_d  = 1'b1;
            end
            `FSPS_CMD_WRITE: begin
              state_d = ST_PROG;
              op_d    = OP_WRITE;
              page_d  = page_f;
              cnt_d   = PROG_CYCLES[`FSPS_CNT_W-1:0];
              busy_d  = 1'b1;
            end
            `FSPS_CMD_LOCK: begin
              state_d = ST_PROG;
              op_d    = OP_LOCK;
              cnt_d   = PROG_CYCLES[`FSPS_CNT_W-1:0];
              lock_d  = lock_q & data_pair_i[`FSPS_LOCK_W-1:0];
            end
            `FSPS_CMD_CLR: begin
              busy_d    = 1'b0;
              buf_clr   = 1'b1;
              loading_d = 1'b0;
            end
            default: begin
            end
          endcase
        end else if (win_q == 3'h1) begin
          state_d = ST_IDLE;
        end else begin
          win_d = win_q - 3'h1;
        end
      end
      ST_PROG: begin
        // halting-section targets stop the cpu, lock programming never does
        halt_d = (op_q != OP_LOCK) && (page_q >= `FSPS_HALT_PAGE);
        if (cnt_q == {`FSPS_CNT_W{1'b0}}) begin
          state_d = ST_IDLE;
          if (op_q == OP_WRITE) begin
            buf_clr   = 1'b1;
            loading_d = 1'b0;
          end
        end else begin
          cnt_d = cnt_q - {{(`FSPS_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // an eeprom write while loading loses everything loaded so far
    if (eewr_s && loading_q && !buf_wr) begin
      buf_clr   = 1'b1;
      loading_d = 1'b0;
    end
    if (cerase_s) begin
      lock_d = `FSPS_LOCK_ERASED;
    end
  end

  // state registers; reset also empties the buffer inside u_buf
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q   <= ST_IDLE;
      cmd_q     <= 6'h00;
      ie_q      <= 1'b0;
      busy_q    <= 1'b0;
      win_q     <= 3'h0;
      cnt_q     <= {`FSPS_CNT_W{1'b0}};
      op_q      <= OP_ERASE;
      page_q    <= {`FSPS_PAGE_W{1'b0}};
      lock_q    <= `FSPS_LOCK_ERASED;
      loading_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cmd_q     <= cmd_d;
      ie_q      <= ie_d;
      busy_q    <= busy_d;
      win_q     <= win_d;
      cnt_q     <= cnt_d;
      op_q      <= op_d;
      page_q    <= page_d;
      lock_q    <= lock_d;
      loading_q <= loading_d;
    end
  end

  // registered outputs; fuse is only observed, never written
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl_status_o    <= 8'h00;
      irq_o            <= 1'b0;
      cpu_halt_o       <= 1'b0;
      read_block_o     <= 1'b0;
      reset_vector_o   <= `FSPS_APP_RESET;
      load_byte_addr_o <= 16'h0000;
      load_byte_sel_o  <= 1'b0;
      load_data_o      <= 8'h00;
      flash_erase_o    <= 1'b0;
      flash_write_o    <= 1'b0;
      flash_page_o     <= {`FSPS_PAGE_W{1'b0}};
      lock_bits_o      <= `FSPS_LOCK_ERASED;
    end else begin
      ctrl_status_o    <= {ie_d, busy_d, 1'b0, (state_d == ST_IDLE) ? 5'h00 : cmd_d[4:0]};
      irq_o            <= ie_d && (state_d == ST_IDLE);
      cpu_halt_o       <= halt_d;
      read_block_o     <= busy_d;
      reset_vector_o   <= fuse_s ? `FSPS_APP_RESET : `FSPS_BOOT_RESET;
      if (load_i) begin
        load_byte_addr_o <= pointer_i;
        load_byte_sel_o  <= pointer_i[0];
        load_data_o      <= pointer_i[0] ? buf_rd_data[15:8] : buf_rd_data[7:0];
      end
      flash_erase_o    <= (state_q == ST_PROG) && (op_q == OP_ERASE);
      flash_write_o    <= (state_q == ST_PROG) && (op_q == OP_WRITE);
      flash_page_o     <= page_q;
      lock_bits_o      <= lock_q;
    end
  end
  // en_bit kept for clarity of status encoding
  wire unused_en = en_bit;
endmodule // fsps_sequencer

// [bench/fsps_cpu_model.sv]
// fsps_cpu_model.sv: cpu core model issuing timed store and load instructions
// assumes one clock shared with the sequencer; every pin moves 1 ns after a rising edge
`timescale 1ns/100ps
module fsps_cpu_model (
  // clock
  input  wire        ref_clk_i,
  // instruction side
  output reg         ctrl_wr_o,
  output reg  [7:0]  ctrl_wdata_o,
  output reg         store_o,
  output reg         load_o,
  output reg  [15:0] pointer_o,
  output reg  [15:0] data_pair_o
);
  initial begin
    {ctrl_wr_o, store_o, load_o} = 3'h0;
    ctrl_wdata_o = 8'h00;
    pointer_o    = 16'h0000;
    data_pair_o  = 16'h0000;
  end

  // register write, then store after gap idle cycles; nothing can interrupt the sequence here
  task spm(input [7:0] cmd, input [15:0] ptr, input [15:0] dat, input int gap);
    @(posedge ref_clk_i);
    #1 pointer_o = ptr;
    data_pair_o  = dat;
    ctrl_wdata_o = cmd;
    ctrl_wr_o    = 1'b1;
    @(posedge ref_clk_i);
    #1 ctrl_wr_o = 1'b0;
    ctrl_wdata_o = ~cmd;
    repeat (gap) @(posedge ref_clk_i);
    if (gap > 0) #1;
    store_o = 1'b1;
    @(posedge ref_clk_i);
    #1 store_o = 1'b0;
    data_pair_o = ~dat; // a released pair must not keep showing the old value
  endtask

  // load instruction; result is registered on the edge that samples the strobe, task returns one edge after the strobe drops
  task lpm(input [15:0] ptr);
    @(posedge ref_clk_i);
    #1 pointer_o = ptr;
    load_o = 1'b1;
    @(posedge ref_clk_i);
    #1 load_o = 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask
endmodule // fsps_cpu_model

// [bench/fsps_props.sv]
// fsps_props.sv: timing checks on the sequencer's cpu-side and flash-side ports
// assumes a bind into fsps_sequencer; one clock, synchronous active-high reset
`timescale 1ns/100ps
`include "fsps_defines.vh"
module fsps_props #(
  parameter PROG_CYCLES = 20
) (
  // clock and reset
  input wire       ref_clk_i,
  input wire       reset_i,
  // watched inputs
  input wire       chip_erase_i,
  input wire       store_i,
  // watched outputs
  input wire [7:0] ctrl_status_o,
  input wire       irq_o,
  input wire       cpu_halt_o,
  input wire       read_block_o,
  input wire       flash_erase_o,
  input wire       flash_write_o,
  input wire [8:0] flash_page_o,
  input wire [5:0] lock_bits_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // programming cycles; cleared when idle so each operation counts afresh
  wire       prog = flash_erase_o | flash_write_o;
  reg [15:0] prog_cnt_q;
  always @(posedge ref_clk_i) begin
    if (reset_i || !prog) prog_cnt_q <= 16'h0000;
    else prog_cnt_q <= prog_cnt_q + 16'h0001;
  end

  // enable seen high, then no store up to the cycle after the window has run out
  sequence s_armed; $rose(ctrl_status_o[0]) ##0 (!store_i) [*5]; endsequence
  sequence s_prog_end; $fell(prog); endsequence
  property p_duration; s_prog_end |-> prog_cnt_q >= PROG_CYCLES && prog_cnt_q <= PROG_CYCLES + 2; endproperty
  property p_irq; (ctrl_status_o[7] && !ctrl_status_o[0]) [*2] |-> irq_o; endproperty
  property p_busy; prog && $past(prog) |-> read_block_o && ctrl_status_o[6]; endproperty
  property p_busy_hold; read_block_o && !store_i && !$past(store_i) |=> read_block_o; endproperty
  property p_lock_open; ctrl_status_o[3] && ctrl_status_o[0] && !read_block_o |=> !read_block_o; endproperty
  property p_halt; prog && $past(prog) |-> cpu_halt_o == (flash_page_o >= `FSPS_HALT_PAGE); endproperty
  property p_page_hold; prog && $past(prog) |-> $stable(flash_page_o); endproperty
  property p_expire; s_armed |-> !ctrl_status_o[0]; endproperty
  property p_done; s_prog_end |-> ##[0:2] !ctrl_status_o[0]; endproperty
  property p_lock_mono; (!chip_erase_i) [*5] |-> (lock_bits_o & ~$past(lock_bits_o)) == 6'h00; endproperty

  a_duration: assert property (p_duration) else $error("programming length off");
  a_irq: assert property (p_irq) else $error("interrupt missing while enable clear");
  a_busy: assert property (p_busy) else $error("busy or read block low while programming");
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped without clear request");
  a_lock_open: assert property (p_lock_open) else $error("lock operation blocked reads");
  a_halt: assert property (p_halt) else $error("cpu halt does not match target section");
  a_page_hold: assert property (p_page_hold) else $error("page moved during programming");
  a_expire: assert property (p_expire) else $error("enable not cleared after window");
  a_done: assert property (p_done) else $error("enable not cleared at completion");
  a_lock_mono: assert property (p_lock_mono) else $error("lock bit cleared without chip erase");
endmodule // fsps_props

bind fsps_sequencer fsps_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .chip_erase_i(chip_erase_i), .store_i(store_i),
  .ctrl_status_o(ctrl_status_o), .irq_o(irq_o), .cpu_halt_o(cpu_halt_o), .read_block_o(read_block_o),
  .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o), .flash_page_o(flash_page_o),
  .lock_bits_o(lock_bits_o));

// [bench/testbench.sv]
// testbench.sv: directed checks of the sequencer through a cpu core model
// assumes fsps_props is bound in; programming shortened to 20 cycles
`timescale 1ns/100ps
module testbench;
  localparam int PC = 20;
  reg         ref_clk_i = 1'b0;
  reg         reset_i   = 1'b1;
  reg         fuse      = 1'b1;
  reg         chip_er   = 1'b0;
  reg         ee_wr     = 1'b0;
  wire        ctrl_wr, store, load, irq, halt, rblk, lsel, ferase, fwrite;
  wire [7:0]  ctrl_wdata, status, ldata;
  wire [15:0] pointer, data_pair, rvec, laddr;
  wire [8:0]  fpage;
  wire [5:0]  lockb;
  int         fail_count = 0;
  int         n_compared = 0;
  // 10 MHz core clock
  always #50 ref_clk_i = ~ref_clk_i;
  fsps_cpu_model u_cpu (.ref_clk_i(ref_clk_i), .ctrl_wr_o(ctrl_wr), .ctrl_wdata_o(ctrl_wdata), .store_o(store),
    .load_o(load), .pointer_o(pointer), .data_pair_o(data_pair));
  fsps_sequencer #(.PROG_CYCLES(PC)) u_dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .boot_vector_fuse_i(fuse), .chip_erase_i(chip_er),
    .ctrl_wr_i(ctrl_wr), .ctrl_wdata_i(ctrl_wdata), .store_i(store), .load_i(load), .pointer_i(pointer),
    .data_pair_i(data_pair), .eeprom_wr_i(ee_wr), .ctrl_status_o(status), .irq_o(irq), .cpu_halt_o(halt),
    .read_block_o(rblk), .reset_vector_o(rvec), .load_byte_addr_o(laddr), .load_byte_sel_o(lsel),
    .load_data_o(ldata), .flash_erase_o(ferase), .flash_write_o(fwrite), .flash_page_o(fpage), .lock_bits_o(lockb));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // bounded poll; a hang here shows up as enable still set
  task wait_idle;
    int i;
    for (i = 0; i < 100 && status[0] !== 1'b0; i++) cyc(1);
    check(16'(status[0]), 16'h0000);
  endtask

  // fuse picks the vector, control writes never move it; interrupt follows its enable
  task t_vector;
    check(rvec, 16'h0000);
    fuse = 1'b0;
    cyc(5);
    check(rvec, 16'h7000);
    u_cpu.spm(8'h80, 16'h0000, 16'h0000, 0);
    cyc(1);
    check(16'(irq), 16'h0001);
    check(rvec, 16'h7000);
    fuse = 1'b1;
    u_cpu.spm(8'h00, 16'h0000, 16'h0000, 0);
    cyc(4);
    check(16'(irq), 16'h0000);
    check(rvec, 16'h0000);
  endtask
  // erase with a late store, a pointer change mid-operation and a busy clear afterwards
  task t_erase(input [8:0] page, input logic halt_x);
    u_cpu.spm(8'h83, {page, 7'h2b}, 16'h1234, 2);
    cyc(3);
    check(16'(ferase), 16'h0001);
    check(16'(fpage), 16'(page));
    check(16'(rblk), 16'h0001);
    check(16'(status[6]), 16'h0001);
    check(16'(halt), 16'(halt_x));
    check(16'(irq), 16'h0000);
    u_cpu.pointer_o = 16'h0000;
    cyc(2);
    check(16'(fpage), 16'(page));
    wait_idle;
    check(16'(irq), 16'h0001);
    check(16'(rblk), 16'h0001);
    u_cpu.spm(8'h91, 16'h0000, 16'h0000, 0);
    cyc(2);
    check(16'(rblk), 16'h0000);
  endtask
  // out-of-order loads, byte reads, and the four ways the buffer empties; each word written once per clear
  task t_buffer;
    u_cpu.spm(8'h01, 16'h080a, 16'hbeef, 0);
    u_cpu.spm(8'h01, 16'h0804, 16'hcafe, 1);
    u_cpu.lpm(16'h080b);
    check(16'(ldata), 16'h00be);
    check(16'(lsel), 16'h0001);
    check(laddr, 16'h080b);
    u_cpu.lpm(16'h0804);
    check(16'(ldata), 16'h00fe);
    u_cpu.spm(8'h05, 16'h0800, 16'h5555, 1);
    cyc(3);
    check(16'(fwrite), 16'h0001);
    check(16'(fpage), 16'h0010);
    wait_idle;
    u_cpu.lpm(16'h080a);
    check(16'(ldata), 16'h00ff);
    u_cpu.spm(8'h11, 16'h0000, 16'h0000, 0);
    u_cpu.spm(8'h01, 16'h080e, 16'ha5c3, 0);
    ee_wr = 1'b1;
    cyc(3);
    ee_wr = 1'b0;
    cyc(3);
    u_cpu.lpm(16'h080e);
    check(16'(ldata), 16'h00ff);
    u_cpu.spm(8'h01, 16'h0812, 16'h7e81, 0);
    u_cpu.spm(8'h11, 16'h0000, 16'h0000, 0);
    u_cpu.lpm(16'h0812);
    check(16'(ldata), 16'h00ff);
    // a mid-run system reset must also empty the buffer
    u_cpu.spm(8'h01, 16'h0814, 16'h1234, 0);
    reset_i = 1'b1;
    cyc(2);
    reset_i = 1'b0;
    u_cpu.lpm(16'h0814);
    check(16'(ldata), 16'h00ff);
  endtask
  // lock bits only ever get programmed; chip erase restores them; a missed store does nothing
  task t_lock;
    u_cpu.spm(8'h09, 16'h0001, 16'h00fa, 1);
    cyc(2);
    check(16'(rblk), 16'h0000);
    wait_idle;
    check(16'(lockb), 16'h003a);
    u_cpu.spm(8'h09, 16'hffff, 16'h00ef, 1);
    wait_idle;
    check(16'(lockb), 16'h002a);
    u_cpu.spm(8'h09, 16'h0001, 16'h00ff, 1);
    wait_idle;
    check(16'(lockb), 16'h002a);
    chip_er = 1'b1;
    cyc(4);
    chip_er = 1'b0;
    cyc(2);
    check(16'(lockb), 16'h003f);
    u_cpu.spm(8'h09, 16'h0001, 16'h00c0, 6);
    cyc(2);
    check(16'(status[3:0]), 16'h0000);
    check(16'(lockb), 16'h003f);
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    t_vector;
    t_erase(9'h010, 1'b0);
    t_erase(9'h0e0, 1'b1);
    t_buffer;
    t_lock;
    summarize;
  end
  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #1000000;
    fail_count++;
    summarize;
  end
endmodule // testbench
